/* hdl/lpc_pkg.sv */
// constants shared by the lighting pwm controller
package lpc_pkg;

    localparam int NUM_CH     = 16;
    localparam int NUM_ALT_CH = 8;
    localparam int NUM_TMR    = 8;
    localparam int GRP_TMR    = 4;
    localparam int TMR_W      = 20;
    localparam int DUTY_W     = 20;
    localparam int TSEL_W     = 2;
    localparam int STEP_W     = 10;
    localparam int CYC_W      = 10;
    localparam int NUM_W      = 10;
    localparam int DIV_W      = 3;

    // clock rates; timers not on the alt clock tick on every ref_clk edge, 50 MHz rather than the 80 MHz bus clock rate
    localparam int REF_CLK_HZ     = 50_000_000;
    localparam int REF_PERIOD_NS  = 20;
    localparam int BUS_CLK_HZ     = 80_000_000;
    localparam int ALT_CLK_HZ     = 8_000_000;
    localparam int ALT_DIV_INT    = REF_CLK_HZ / ALT_CLK_HZ;
    localparam logic [DIV_W-1:0] ALT_DIV_LAST = DIV_W'(ALT_DIV_INT - 1);

    // default period of 1 ms
    localparam int PERIOD_NS  = 1_000_000;
    localparam int PERIOD_CYC = PERIOD_NS / REF_PERIOD_NS;
    localparam logic [TMR_W-1:0]  RANGE_RST = TMR_W'(PERIOD_CYC - 1);
    localparam logic [DUTY_W-1:0] DUTY_RST  = 20'h0_0000;
    localparam logic [DUTY_W-1:0] DUTY_MAX  = 20'hf_ffff;
    localparam logic [TMR_W-1:0]  CNT_RST   = 20'h0_0000;

    typedef enum logic [1:0] {
        LPC_IDLE = 2'b00,
        LPC_RUN  = 2'b01,
        LPC_FIN  = 2'b11
    } lpc_fade_type;

endpackage

/* hdl/lpc_channel.sv */
// one pwm channel: duty register, fade stepper and output compare
module lpc_channel
    import lpc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              chan_en,
    input  wire logic [TMR_W-1:0]  count,
    input  wire logic              wrap,
    input  wire logic              duty_load,
    input  wire logic [DUTY_W-1:0] duty_in,
    input  wire logic              fade_start,
    input  wire logic              fade_up,
    input  wire logic [STEP_W-1:0] fade_step,
    input  wire logic [CYC_W-1:0]  fade_cycles,
    input  wire logic [NUM_W-1:0]  fade_num,
    input  wire logic              done_clr,
    output logic                   pwm_out,
    output logic [DUTY_W-1:0]      duty_now,
    output logic                   fade_busy,
    output logic                   fade_done
);

    lpc_fade_type      state;
    logic              f_up;
    logic [DUTY_W-1:0] f_step;
    logic [CYC_W-1:0]  f_cyc;
    logic [CYC_W-1:0]  cyc_cnt;
    logic [NUM_W-1:0]  f_left;
    logic              step_now;
    logic [DUTY_W-1:0] next_duty;

    assign step_now = (state == LPC_RUN) && wrap && (cyc_cnt + 1'b1 >= f_cyc);

    always_comb begin
        next_duty = duty_now;
        if (f_up) begin
            next_duty = (duty_now > DUTY_MAX - f_step) ? DUTY_MAX : duty_now + f_step;
        end else begin
            next_duty = (duty_now < f_step) ? DUTY_RST : duty_now - f_step;
        end
    end

    // fade sequencer; a direct duty write aborts a running fade
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state   <= LPC_IDLE;
            f_up    <= 1'b0;
            f_step  <= DUTY_RST;
            f_cyc   <= '0;
            f_left  <= '0;
            cyc_cnt <= '0;
        end else if (duty_load) begin
            state <= LPC_IDLE;
        end else if (fade_start) begin
            state   <= (fade_num == '0) ? LPC_FIN : LPC_RUN;
            f_up    <= fade_up;
            f_step  <= {{(DUTY_W-STEP_W){1'b0}}, fade_step};
            f_cyc   <= fade_cycles;
            f_left  <= fade_num;
            cyc_cnt <= '0;
        end else begin
            case (state)
                LPC_IDLE: begin
                    state <= LPC_IDLE;
                end
                LPC_RUN: begin
                    if (step_now) begin
                        cyc_cnt <= '0;
                        f_left  <= f_left - 1'b1;
                        if (f_left == NUM_W'(1)) begin
                            state <= LPC_FIN;
                        end
                    end else if (wrap) begin
                        cyc_cnt <= cyc_cnt + 1'b1;
                    end
                end
                LPC_FIN: begin
                    state <= LPC_IDLE;
                end
                default: begin
                    state <= LPC_IDLE;
                end
            endcase
        end
    end

    // duty register: direct write or hardware step
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            duty_now <= DUTY_RST;
        end else if (duty_load) begin
            duty_now <= duty_in;
        end else if (step_now && !fade_start) begin
            duty_now <= next_duty;
        end
    end

    // done flag: completion beats a simultaneous clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fade_done <= 1'b0;
        end else if (state == LPC_FIN && !duty_load && !fade_start) begin
            fade_done <= 1'b1;
        end else if (done_clr) begin
            fade_done <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fade_busy <= 1'b0;
        end else begin
            fade_busy <= (state == LPC_RUN) && !(step_now && f_left == NUM_W'(1));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= chan_en && (count < duty_now);
        end
    end

endmodule

/* hdl/lpc_top.sv */
// sixteen-channel lighting pwm controller: timers, clock divider, channels
//////////////////////////////////////////////////////////////////////////////

// Contract
// - Sixteen channels each have their own period and duty setting; the period here comes from one of four timers shared by a group of eight.
// - By default every channel counts on the main bus-rate clock; the timers here tick on every 50 MHz ref_clk edge, not at 80 MHz.
// - Channels eight to fifteen may count on a slower oscillator-rate clock instead.
// - Each channel picks one 20-bit timer whose programmable range sets the period.
// - Duty resolution reaches 16 bits at a 1 ms period; the 50 MHz ref_clk gives only 50,000 steps, under 16 bits.
// - A duty written by software takes effect on the output at once.
// - Hardware can step the duty up or down by itself to make fades.
module lpc_top
    import lpc_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    input  wire logic [NUM_TMR*TMR_W-1:0]  timer_range,
    input  wire logic [NUM_TMR-1:0]        timer_pause,
    input  wire logic [NUM_TMR-1:0]        timer_clear,
    input  wire logic [GRP_TMR-1:0]        timer_alt_clk,
    input  wire logic [NUM_CH-1:0]         chan_en,
    input  wire logic [NUM_CH*TSEL_W-1:0]  chan_timer_sel,
    input  wire logic [NUM_CH-1:0]         chan_duty_load,
    input  wire logic [NUM_CH*DUTY_W-1:0]  chan_duty,
    input  wire logic [NUM_CH-1:0]         chan_fade_start,
    input  wire logic [NUM_CH-1:0]         chan_fade_up,
    input  wire logic [NUM_CH*STEP_W-1:0]  chan_fade_step,
    input  wire logic [NUM_CH*CYC_W-1:0]   chan_fade_cycles,
    input  wire logic [NUM_CH*NUM_W-1:0]   chan_fade_num,
    input  wire logic [NUM_CH-1:0]         chan_done_clr,
    output logic      [NUM_CH-1:0]         pwm_out,
    output logic      [NUM_CH*DUTY_W-1:0]  chan_duty_now,
    output logic      [NUM_CH-1:0]         chan_fade_busy,
    output logic      [NUM_CH-1:0]         chan_fade_done,
    output logic      [NUM_TMR*TMR_W-1:0]  timer_count,
    output logic      [NUM_TMR-1:0]        timer_wrap
);

    //////////////////////////////////////////////////////////////////////////
    // oscillator-rate enable from the reference clock

    logic [DIV_W-1:0] div_cnt;
    logic             alt_tick;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_cnt  <= '0;
            alt_tick <= 1'b0;
        end else if (div_cnt == ALT_DIV_LAST) begin
            div_cnt  <= '0;
            alt_tick <= 1'b1;
        end else begin
            div_cnt  <= div_cnt + 1'b1;
            alt_tick <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // timers: 0..3 serve channels 0..7, 4..7 serve channels 8..15

    logic [TMR_W-1:0] cnt   [NUM_TMR];
    logic [TMR_W-1:0] range [NUM_TMR];
    logic             tick  [NUM_TMR];
    logic [NUM_TMR-1:0] wrap_now;

    genvar t;
    generate
        for (t = 0; t < NUM_TMR; t = t + 1) begin : g_tmr
            assign range[t] = timer_range[t*TMR_W +: TMR_W];

            if (t < GRP_TMR) begin : g_bus
                assign tick[t] = 1'b1;
            end else begin : g_alt
                assign tick[t] = timer_alt_clk[t-GRP_TMR] ? alt_tick : 1'b1;
            end

            assign wrap_now[t] = tick[t] && !timer_pause[t] && (cnt[t] >= range[t]);

            // count 0..range then back to zero
            always_ff @(posedge ref_clk) begin
                if (sys_rst || timer_clear[t]) begin
                    cnt[t] <= CNT_RST;
                end else if (tick[t] && !timer_pause[t]) begin
                    if (cnt[t] >= range[t]) begin
                        cnt[t] <= CNT_RST;
                    end else begin
                        cnt[t] <= cnt[t] + 1'b1;
                    end
                end
            end

            always_ff @(posedge ref_clk) begin
                if (sys_rst || timer_clear[t]) begin
                    timer_wrap[t] <= 1'b0;
                end else begin
                    timer_wrap[t] <= wrap_now[t];
                end
            end

            assign timer_count[t*TMR_W +: TMR_W] = cnt[t];
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // channels, each bound to one timer of its own group

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
            localparam int BASE = (c < NUM_CH - NUM_ALT_CH) ? 0 : GRP_TMR;
            logic [TSEL_W-1:0] sel;
            logic [TMR_W-1:0]  ch_cnt;
            logic              ch_wrap;

            assign sel     = chan_timer_sel[c*TSEL_W +: TSEL_W];
            assign ch_cnt  = cnt[BASE + int'(sel)];
            assign ch_wrap = wrap_now[BASE + int'(sel)];

            // full 20-bit compare gives 50,000 duty steps over a 1 ms range
            lpc_channel u_ch (
                .ref_clk     (ref_clk),
                .sys_rst     (sys_rst),
                .chan_en     (chan_en[c]),
                .count       (ch_cnt),
                .wrap        (ch_wrap),
                .duty_load   (chan_duty_load[c]),
                .duty_in     (chan_duty[c*DUTY_W +: DUTY_W]),
                .fade_start  (chan_fade_start[c]),
                .fade_up     (chan_fade_up[c]),
                .fade_step   (chan_fade_step[c*STEP_W +: STEP_W]),
                .fade_cycles (chan_fade_cycles[c*CYC_W +: CYC_W]),
                .fade_num    (chan_fade_num[c*NUM_W +: NUM_W]),
                .done_clr    (chan_done_clr[c]),
                .pwm_out     (pwm_out[c]),
                .duty_now    (chan_duty_now[c*DUTY_W +: DUTY_W]),
                .fade_busy   (chan_fade_busy[c]),
                .fade_done   (chan_fade_done[c])
            );
        end
    endgenerate

endmodule

/* tb/lpc_sva.sv */
// assertion checker bound to the lighting pwm controller top
module lpc_sva
    import lpc_pkg::*;
(
    input wire logic                     ref_clk,
    input wire logic                     sys_rst,
    input wire logic [NUM_TMR*TMR_W-1:0] timer_range,
    input wire logic [NUM_TMR-1:0]       timer_pause,
    input wire logic [NUM_TMR-1:0]       timer_clear,
    input wire logic [GRP_TMR-1:0]       timer_alt_clk,
    input wire logic [NUM_CH-1:0]        chan_en,
    input wire logic [NUM_CH*TSEL_W-1:0] chan_timer_sel,
    input wire logic [NUM_CH-1:0]        chan_duty_load,
    input wire logic [NUM_CH*DUTY_W-1:0] chan_duty,
    input wire logic [NUM_CH-1:0]        chan_fade_start,
    input wire logic [NUM_CH*NUM_W-1:0]  chan_fade_num,
    input wire logic [NUM_CH-1:0]        chan_done_clr,
    input wire logic [NUM_CH-1:0]        pwm_out,
    input wire logic [NUM_CH*DUTY_W-1:0] chan_duty_now,
    input wire logic [NUM_CH-1:0]        chan_fade_busy,
    input wire logic [NUM_CH-1:0]        chan_fade_done,
    input wire logic [NUM_TMR*TMR_W-1:0] timer_count,
    input wire logic [NUM_TMR-1:0]       timer_wrap
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic [TMR_W-1:0] c0 = timer_count[19:0];
    wire logic [TMR_W-1:0] c4 = timer_count[99:80];
    wire logic [TMR_W-1:0] sc = timer_count[chan_timer_sel[1:0]*TMR_W +: TMR_W];
    property p_count;
        !timer_pause[0] && !timer_clear[0] && c0 < timer_range[19:0] |=> c0 == $past(c0) + 1'b1;
    endproperty
    property p_wrap;
        timer_wrap[0] |-> c0 == 20'h0_0000;
    endproperty
    property p_pwm;
        !$past(sys_rst) |-> pwm_out[0] == $past(chan_en[0] && sc < chan_duty_now[19:0]);
    endproperty
    property p_load;
        chan_duty_load[0] |=> chan_duty_now[19:0] == $past(chan_duty[19:0]);
    endproperty
    property p_busy;
        chan_fade_start[1] && !chan_duty_load[1] && chan_fade_num[19:10] > 10'h001
            |=> ##1 chan_fade_busy[1];
    endproperty
    property p_done;
        !$past(sys_rst) && $fell(chan_fade_busy[1]) && !$past(chan_duty_load[1])
            && !$past(chan_duty_load[1], 2) && !$past(chan_fade_start[1])
            && !$past(chan_fade_start[1], 2) |=> chan_fade_done[1];
    endproperty
    property p_sticky;
        chan_fade_done[1] && !chan_done_clr[1] |=> chan_fade_done[1];
    endproperty
    property p_alt;
        timer_alt_clk[0] && $changed(c4) && c4 != 0 |=> $stable(c4)[*5];
    endproperty
    property p_pause;
        timer_pause[0] && !timer_clear[0] |=> c0 == $past(c0);
    endproperty
    property p_clear;
        timer_clear[0] |=> c0 == 20'h0_0000 && !timer_wrap[0];
    endproperty
    a_count: assert property (p_count) else $error("timer step wrong");
    a_wrap: assert property (p_wrap) else $error("wrap without zero count");
    a_pwm: assert property (p_pwm) else $error("pwm compare wrong");
    a_load: assert property (p_load) else $error("duty load late");
    a_busy: assert property (p_busy) else $error("fade not busy");
    a_done: assert property (p_done) else $error("fade done missing");
    a_sticky: assert property (p_sticky) else $error("done dropped");
    a_alt: assert property (p_alt) else $error("alt tick too fast");
    a_pause: assert property (p_pause) else $error("paused timer moved");
    a_clear: assert property (p_clear) else $error("cleared timer not zero");
    c_wrap: cover property (timer_wrap[0]);
    c_done: cover property (chan_fade_done[1]);
    c_alt: cover property (timer_wrap[4]);
endmodule

bind lpc_top lpc_sva chk_u (.*);

/* tb/lpc_top_tb.sv */
// self-checking bench for the lighting pwm controller
module lpc_top_tb
    import lpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     ref_clk = 1'b0;
    logic                     sys_rst = 1'b1;
    logic [NUM_TMR*TMR_W-1:0] timer_range = {{4{20'h0_0003}}, {2{20'h0_0009}}, 20'h0_0004,
                                             20'h0_0009};
    logic [NUM_TMR-1:0]       timer_pause = '0, timer_clear = '0;
    logic [GRP_TMR-1:0]       timer_alt_clk = 4'h1;
    logic [NUM_CH-1:0]        chan_en = '1, chan_duty_load = '0, chan_fade_start = '0;
    logic [NUM_CH-1:0]        chan_fade_up = '0, chan_done_clr = '0;
    logic [NUM_CH*TSEL_W-1:0] chan_timer_sel = '0;
    logic [NUM_CH*DUTY_W-1:0] chan_duty = '0, seen = '0;
    logic [NUM_CH*STEP_W-1:0] chan_fade_step = '0;
    logic [NUM_CH*CYC_W-1:0]  chan_fade_cycles = '0;
    logic [NUM_CH*NUM_W-1:0]  chan_fade_num = '0;
    logic [NUM_CH-1:0]        pwm_out, chan_fade_busy, chan_fade_done;
    logic [NUM_CH*DUTY_W-1:0] chan_duty_now;
    logic [NUM_TMR*TMR_W-1:0] timer_count;
    logic [NUM_TMR-1:0]       timer_wrap;
    logic [23:0]              notes[$];
    logic [15:0]              seed = 16'h1807;
    logic [7:0]               hi;
    int                       failures = 0, compares = 0, cycles = 0;

    lpc_top dut_u (.*);

    always #10 ref_clk = ~ref_clk;
    //////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp_duty(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: duty note got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: value got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic load(input int c, input logic [19:0] d);
        chan_duty[c*DUTY_W +: DUTY_W] <= d;
        chan_duty_load[c] <= 1'b1;
        notes.push_back({4'(c), d});
    endtask
    task automatic fade(input int c, input bit up, input logic [9:0] st, input logic [9:0] n);
        chan_fade_up[c] <= up;
        chan_fade_step[c*STEP_W +: STEP_W] <= st;
        chan_fade_num[c*NUM_W +: NUM_W] <= n;
        chan_fade_cycles[c*CYC_W +: CYC_W] <= 10'(c > 7 ? 2 : 1);
        chan_fade_start[c] <= 1'b1;
    endtask
    task automatic wait_done(input int c);
        for (int i = 0; i < 1000 && chan_fade_done[c] !== 1'b1; i++)
            @(posedge ref_clk);
    endtask
    //////////////////////////////////////////////////////////////////////////
    // duty monitor: every change of a channel's duty consumes the oldest note
    always @(negedge ref_clk) begin
        for (int c = 0; c < NUM_CH; c++)
            if (chan_duty_now[c*DUTY_W +: DUTY_W] !== seen[c*DUTY_W +: DUTY_W])
                cmp_duty({4'(c), chan_duty_now[c*DUTY_W +: DUTY_W]},
                         notes.size() > 0 ? notes.pop_front() : 24'hff_ffff);
        seen <= chan_duty_now;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        cmp_flag(8'(chan_duty_now == '0 && pwm_out == '0), 8'h01);
        for (int c = 0; c < NUM_CH; c++) begin
            seed = lfsr(seed);
            load(c, {4'h0, seed} | 20'h0_0001);
        end
        @(posedge ref_clk);
        chan_duty_load <= '0;
        repeat (2) @(posedge ref_clk);
        $display("test independent loads done");
        chan_timer_sel[1:0] <= 2'h1;
        load(0, 20'h0_0003);
        @(posedge ref_clk);
        chan_duty_load <= '0;
        repeat (3) @(posedge ref_clk);
        hi = 8'h00;
        repeat (20) begin
            @(negedge ref_clk);
            hi = hi + 8'(pwm_out[0]);
        end
        cmp_flag(hi, 8'h0c);
        @(posedge ref_clk);
        hi = 8'h00;
        timer_pause[0] <= 1'b1;
        chan_en[0]     <= 1'b0;
        @(posedge ref_clk);
        repeat (4) begin
            @(negedge ref_clk);
            hi = hi + 8'(pwm_out[0]);
        end
        @(posedge ref_clk);
        timer_pause[0] <= 1'b0;
        timer_clear[0] <= 1'b1;
        @(posedge ref_clk);
        timer_clear[0] <= 1'b0;
        chan_en[0]     <= 1'b1;
        @(negedge ref_clk);
        cmp_flag({hi[6:0], timer_count[19:0] == 20'h0_0000}, 8'h01);
        $display("test pwm compare done");
        @(posedge ref_clk);
        load(1, 20'h0_0100);
        load(8, 20'h0_0010);
        @(posedge ref_clk);
        chan_duty_load <= '0;
        notes.push_back({4'h1, 20'h0_0103});
        notes.push_back({4'h1, 20'h0_0106});
        fade(1, 1'b1, 10'h003, 10'h002);
        @(posedge ref_clk);
        chan_fade_start <= '0;
        wait_done(1);
        cmp_flag(8'(chan_fade_done[1]), 8'h01);
        chan_done_clr[1] <= 1'b1;
        @(posedge ref_clk);
        chan_done_clr[1] <= 1'b0;
        @(posedge ref_clk);
        cmp_flag(8'(chan_fade_done[1]), 8'h00);
        $display("test fade up done");
        for (int i = 0; i < 4; i++)
            notes.push_back({4'h8, 20'(i < 3 ? 16'h0010 - 16'(5 * (i + 1)) : 16'h0000)});
        fade(8, 1'b0, 10'h005, 10'h004);
        @(posedge ref_clk);
        chan_fade_start <= '0;
        wait_done(8);
        cmp_flag(8'(chan_fade_done[8]), 8'h01);
        cmp_flag(8'(notes.size()), 8'h00);
        $display("test alt clock fade down done");
        wrap_up();
    end
endmodule
